// file: hdl/twm_pkg.sv
package twm_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned HALF_BIT_NS = 5000;
  localparam int unsigned HALF_BIT_CYC = HALF_BIT_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam int unsigned ADDR_W = 2;
  localparam logic [1:0] CTRL_OFS = 2'h0;
  localparam logic [1:0] STAT_OFS = 2'h1;
  localparam logic [1:0] DATA_OFS = 2'h2;

  localparam int unsigned CTRL_FLAG_BIT = 7;
  localparam int unsigned CTRL_ACKEN_BIT = 6;
  localparam int unsigned CTRL_START_BIT = 5;
  localparam int unsigned CTRL_STOP_BIT = 4;
  localparam int unsigned CTRL_WCOL_BIT = 3;
  localparam int unsigned CTRL_EN_BIT = 2;
  localparam int unsigned CTRL_IE_BIT = 0;
  localparam int unsigned STAT_PRESC_LSB = 0;
  localparam int unsigned STAT_PRESC_W = 2;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hFF;
  localparam logic [7:0] STAT_MASK = 8'hF8;

  // ------------------------------------------------------------
  // status codes
  // ------------------------------------------------------------
  localparam logic [7:0] ST_START = 8'h08;
  localparam logic [7:0] ST_RSTART = 8'h10;
  localparam logic [7:0] ST_AW_ACK = 8'h18;
  localparam logic [7:0] ST_AW_NACK = 8'h20;
  localparam logic [7:0] ST_D_ACK = 8'h28;
  localparam logic [7:0] ST_D_NACK = 8'h30;
  localparam logic [7:0] ST_ARB = 8'h38;
  localparam logic [7:0] ST_AR_ACK = 8'h40;
  localparam logic [7:0] ST_AR_NACK = 8'h48;
  localparam logic [7:0] ST_IDLE = 8'hF8;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TWM_CMD_START = 2'b00,
    TWM_CMD_STOP = 2'b01,
    TWM_CMD_BYTE = 2'b10
  } twm_cmd_type;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'b000,
    SQ_WAIT_FREE = 3'b001,
    SQ_START = 3'b010,
    SQ_ADDR = 3'b011,
    SQ_DATA = 3'b100,
    SQ_STOP = 3'b101
  } twm_seq_type;

endpackage

// file: hdl/twm_bit_if.sv
interface twm_bit_if;
  twm_pkg::twm_cmd_type cmd;
  logic cmd_valid;
  logic [7:0] tx_byte;
  logic done;
  logic ack_rx;
  logic arb_lost;
  logic bus_busy;
  logic held;
  logic scl_s;
  logic sda_s;
  logic scl_low;
  logic sda_low;

  modport seq (
    output cmd, cmd_valid, tx_byte, scl_s, sda_s,
    input done, ack_rx, arb_lost, bus_busy, held, scl_low, sda_low
  );
  modport eng (
    input cmd, cmd_valid, tx_byte, scl_s, sda_s,
    output done, ack_rx, arb_lost, bus_busy, held, scl_low, sda_low
  );
endinterface

// file: hdl/twm_bit_engine.sv
module twm_bit_engine #(
  parameter int unsigned HALF_CYC = twm_pkg::HALF_BIT_CYC
) (
  // clock and reset
  input logic clk,
  input logic reset_n,
  // sequencer side
  twm_bit_if.eng bif
);
  import twm_pkg::*;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_START = 2'b01,
    ENG_STOP = 2'b10,
    ENG_BITS = 2'b11
  } twm_eng_type;

  localparam int unsigned TW = $clog2(HALF_CYC + 1);
  localparam logic [TW-1:0] RELOAD = TW'(HALF_CYC - 1);

  twm_eng_type st_r;
  logic [1:0] step_r;
  logic [3:0] bit_r;
  logic [TW-1:0] tmr_r;
  logic [7:0] sh_r;
  logic held_r, busy_r, done_r, ack_r, arb_r;
  logic scl_low_r, sda_low_r, scl_d_r, sda_d_r, sda_lag_r;
  logic scl_low_nxt, sda_low_nxt;

  // ------------------------------------------------------------
  // bus monitor and step decode
  // ------------------------------------------------------------
  wire start_seen = bif.scl_s && scl_d_r && sda_d_r && !bif.sda_s;
  wire stop_seen = bif.scl_s && scl_d_r && !sda_d_r && bif.sda_s;
  wire tick = (tmr_r == '0);
  wire stretch = (st_r != ENG_IDLE) && !scl_low_r && !bif.scl_s;
  wire last = (st_r == ENG_START && step_r == 2'd3) || (st_r == ENG_STOP && step_r == 2'd2)
              || (st_r == ENG_BITS && step_r[0]);
  wire sample = (st_r == ENG_BITS) && step_r[0] && tick && !stretch;
  wire lost = sample && (bit_r != 4'd8) && sh_r[7] && !bif.sda_s;
  wire twm_eng_type eng_go = (bif.cmd == TWM_CMD_START) ? ENG_START :
                             (bif.cmd == TWM_CMD_STOP) ? ENG_STOP : ENG_BITS;

  always_comb begin
    scl_low_nxt = held_r;
    sda_low_nxt = 1'b0;
    unique case (st_r)
      ENG_IDLE: begin
        scl_low_nxt = held_r;
      end
      ENG_START: begin
        scl_low_nxt = (step_r == 2'd0) ? held_r : (step_r == 2'd3);
        sda_low_nxt = step_r[1];
      end
      ENG_STOP: begin
        scl_low_nxt = (step_r == 2'd0);
        sda_low_nxt = (step_r != 2'd2);
      end
      ENG_BITS: begin
        scl_low_nxt = !step_r[0];
        sda_low_nxt = (bit_r != 4'd8) && !sh_r[7];
      end
    endcase
  end

  // ------------------------------------------------------------
  // line drive and bus state
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      sda_lag_r <= 1'b0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      busy_r <= 1'b0;
    end else begin
      scl_low_r <= scl_low_nxt;
      // data trails clock by a cycle: no data edge while clock falls
      sda_lag_r <= sda_low_nxt;
      sda_low_r <= sda_lag_r;
      scl_d_r <= bif.scl_s;
      sda_d_r <= bif.sda_s;
      busy_r <= start_seen || (busy_r && !stop_seen);
    end
  end

  // ------------------------------------------------------------
  // condition and bit sequencing
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_r <= ENG_IDLE;
      step_r <= 2'd0;
      bit_r <= 4'd0;
      tmr_r <= '0;
      sh_r <= 8'hFF;
      held_r <= 1'b0;
      done_r <= 1'b0;
      ack_r <= 1'b0;
      arb_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (st_r == ENG_IDLE) begin
        if (bif.cmd_valid) begin
          st_r <= eng_go;
          step_r <= 2'd0;
          bit_r <= 4'd0;
          sh_r <= bif.tx_byte;
          tmr_r <= RELOAD;
          arb_r <= 1'b0;
        end
      end else if (stretch) begin
        tmr_r <= tmr_r;
      end else if (!tick) begin
        tmr_r <= tmr_r - 1'b1;
      end else if (lost) begin
        // lost the bus: let go of both lines at once
        st_r <= ENG_IDLE;
        held_r <= 1'b0;
        arb_r <= 1'b1;
        done_r <= 1'b1;
      end else if (last && st_r == ENG_BITS && bit_r != 4'd8) begin
        bit_r <= bit_r + 4'd1;
        sh_r <= {sh_r[6:0], 1'b1};
        step_r <= 2'd0;
        tmr_r <= RELOAD;
      end else if (last) begin
        st_r <= ENG_IDLE;
        done_r <= 1'b1;
        held_r <= (st_r != ENG_STOP);
        ack_r <= !bif.sda_s;
      end else begin
        step_r <= step_r + 2'd1;
        tmr_r <= RELOAD;
      end
    end
  end

  assign bif.done = done_r;
  assign bif.ack_rx = ack_r;
  assign bif.arb_lost = arb_r;
  assign bif.bus_busy = busy_r;
  assign bif.held = held_r;
  assign bif.scl_low = scl_low_r;
  assign bif.sda_low = sda_low_r;

endmodule

// file: hdl/twm_master.sv
// What this block does
// - start goes out on a free bus, or at once while this master holds the bus
// - after start: flag set, code 0x08
// - address direction bit selects transmit or receive
// - writing one clears flag, resumes transfer
// - write address done: 0x18, 0x20 or 0x38
// - data write while flag low collides, ignored
// - in data states, cleared flag sends byte
// - data done: 0x28, 0x30 or 0x38
// - stop sent, then stop bit self-clears
// - repeated start reports 0x10, keeps bus
// - read address after 0x10 enters receive operation
// - start and stop: stop, clear stop, start
// - 0x38 without start releases bus, unaddressed
// - 0x38 with start restarts on free bus
// - flag set holds transfer suspended
//
// The register addresses and the strobed register port were decided locally.
module twm_master #(
  parameter int unsigned HALF_CYC = twm_pkg::HALF_BIT_CYC
) (
  // clock and reset
  input logic clk,
  input logic reset_n,
  // register port
  input logic [twm_pkg::ADDR_W-1:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata,
  // two-wire pins
  input logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // status outputs
  output logic irq,
  output logic master_receive_mode,
  output logic unaddressed_slave
);
  import twm_pkg::*;

  if (HALF_CYC < 2 || HALF_CYC > 4096) begin : g_bad_half
    $error("half bit count out of range");
  end

  twm_bit_if bif();

  twm_bit_engine #(.HALF_CYC(HALF_CYC)) u_engine (
    .clk(clk),
    .reset_n(reset_n),
    .bif(bif)
  );

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic scl_m_r, scl_s_r, sda_m_r, sda_s_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
    end
  end

  assign bif.scl_s = scl_s_r;
  assign bif.sda_s = sda_s_r;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, ie_r;
  logic [7:0] code_r, code_nxt, data_r, rdata_r;
  logic [STAT_PRESC_W-1:0] presc_r;
  logic rx_r, rep_r, irq_r, unaddr_r;
  twm_seq_type sq_r, sq_nxt;
  logic cmd_v;
  twm_cmd_type cmd;

  wire ctrl_wr = reg_wr && (reg_addr == CTRL_OFS);
  wire stat_wr = reg_wr && (reg_addr == STAT_OFS);
  wire data_wr = reg_wr && (reg_addr == DATA_OFS);
  wire w_flag = reg_wdata[CTRL_FLAG_BIT];
  wire w_sta = reg_wdata[CTRL_START_BIT];
  wire w_sto = reg_wdata[CTRL_STOP_BIT];
  wire go = ctrl_wr && w_flag && reg_wdata[CTRL_EN_BIT];
  wire act = go && (sq_r == SQ_IDLE);
  wire code_lost = (code_r == ST_ARB);
  wire code_addr = (code_r == ST_START) || (code_r == ST_RSTART);
  wire code_data = (code_r == ST_AW_ACK) || (code_r == ST_AW_NACK) || (code_r == ST_D_ACK)
                   || (code_r == ST_D_NACK);
  wire addr_rd = data_r[0];
  wire eng_done = bif.done;
  wire flag_set = eng_done && (sq_r == SQ_START || sq_r == SQ_ADDR || sq_r == SQ_DATA);
  wire flag_clr = ctrl_wr && w_flag;
  wire data_ok = data_wr && flag_r;
  wire wcol_set = data_wr && !flag_r;
  wire stop_done = eng_done && (sq_r == SQ_STOP);
  wire lost_release = act && !w_sta && !w_sto && code_lost;
  wire start_issue = cmd_v && (cmd == TWM_CMD_START);
  wire rx_enter = eng_done && (sq_r == SQ_ADDR) && addr_rd && !bif.arb_lost;
  wire [7:0] stat_rd = (code_r & STAT_MASK) | {{(8 - STAT_PRESC_W){1'b0}}, presc_r};
  wire [7:0] ctrl_rd = {flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, 1'b0, ie_r};
  wire [7:0] rd_mux = (reg_addr == CTRL_OFS) ? ctrl_rd :
                      (reg_addr == STAT_OFS) ? stat_rd :
                      (reg_addr == DATA_OFS) ? data_r : 8'h00;

  // ------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------
  always_comb begin
    sq_nxt = sq_r;
    cmd_v = 1'b0;
    cmd = TWM_CMD_START;
    unique case (sq_r)
      SQ_IDLE: begin
        if (act && w_sto) begin
          cmd_v = 1'b1;
          cmd = TWM_CMD_STOP;
          sq_nxt = SQ_STOP;
        end else if (act && w_sta && bif.held) begin
          cmd_v = 1'b1;
          sq_nxt = SQ_START;
        end else if (act && w_sta) begin
          sq_nxt = SQ_WAIT_FREE;
        end else if (act && code_addr) begin
          cmd_v = 1'b1;
          cmd = TWM_CMD_BYTE;
          sq_nxt = SQ_ADDR;
        end else if (act && code_data) begin
          cmd_v = 1'b1;
          cmd = TWM_CMD_BYTE;
          sq_nxt = SQ_DATA;
        end
      end
      SQ_WAIT_FREE: begin
        if (!bif.bus_busy) begin
          cmd_v = 1'b1;
          sq_nxt = SQ_START;
        end
      end
      SQ_START, SQ_ADDR, SQ_DATA: begin
        if (eng_done) begin
          sq_nxt = SQ_IDLE;
        end
      end
      SQ_STOP: begin
        if (eng_done) begin
          sq_nxt = sta_r ? SQ_WAIT_FREE : SQ_IDLE;
        end
      end
      default: begin
        sq_nxt = SQ_IDLE;
      end
    endcase
  end

  always_comb begin
    code_nxt = code_r;
    if (lost_release || stop_done) begin
      code_nxt = ST_IDLE;
    end else if (eng_done && sq_r == SQ_START) begin
      code_nxt = rep_r ? ST_RSTART : ST_START;
    end else if (eng_done && sq_r == SQ_ADDR) begin
      code_nxt = bif.arb_lost ? ST_ARB :
                 addr_rd ? (bif.ack_rx ? ST_AR_ACK : ST_AR_NACK) :
                 (bif.ack_rx ? ST_AW_ACK : ST_AW_NACK);
    end else if (eng_done && sq_r == SQ_DATA) begin
      code_nxt = bif.arb_lost ? ST_ARB : (bif.ack_rx ? ST_D_ACK : ST_D_NACK);
    end
  end

  assign bif.cmd_valid = cmd_v;
  assign bif.cmd = cmd;
  assign bif.tx_byte = data_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sq_r <= SQ_IDLE;
      code_r <= ST_IDLE;
      rep_r <= 1'b0;
      rx_r <= 1'b0;
      unaddr_r <= 1'b0;
    end else begin
      sq_r <= sq_nxt;
      code_r <= code_nxt;
      rep_r <= start_issue ? bif.held : rep_r;
      rx_r <= rx_enter || (rx_r && !start_issue && !stop_done);
      unaddr_r <= lost_release || (unaddr_r && !act);
    end
  end

  // ------------------------------------------------------------
  // software visible bits
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      {flag_r, ack_en_r, sta_r, sto_r, wcol_r, en_r, ie_r} <= {CTRL_RST[7:3], CTRL_RST[2], CTRL_RST[0]};
      data_r <= DATA_RST;
      presc_r <= '0;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      flag_r <= flag_set || (flag_r && !flag_clr);
      wcol_r <= wcol_set || (wcol_r && !data_ok);
      sto_r <= ctrl_wr ? w_sto : (sto_r && !stop_done);
      if (ctrl_wr) begin
        ack_en_r <= reg_wdata[CTRL_ACKEN_BIT];
        sta_r <= w_sta;
        en_r <= reg_wdata[CTRL_EN_BIT];
        ie_r <= reg_wdata[CTRL_IE_BIT];
      end
      if (data_ok) begin
        data_r <= reg_wdata;
      end
      if (stat_wr) begin
        presc_r <= reg_wdata[STAT_PRESC_LSB +: STAT_PRESC_W];
      end
      rdata_r <= reg_rd ? rd_mux : 8'h00;
      irq_r <= flag_r && ie_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata = rdata_r;
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = bif.scl_low && en_r;
  assign sda_oe = bif.sda_low && en_r;
  assign irq = irq_r;
  assign master_receive_mode = rx_r;
  assign unaddressed_slave = unaddr_r;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence seq_stop_start_req;
    (sq_r == SQ_IDLE) && go && w_sto && w_sta;
  endsequence

  sequence seq_stop_finish;
    (sq_r == SQ_STOP) && eng_done;
  endsequence

  chk_start_free: assert property (start_issue && !bif.held |-> !bif.bus_busy)
    else $error("start issued on busy bus");
  chk_start_code: assert property ((sq_r == SQ_START) && eng_done && !rep_r
                                   |=> flag_r && (code_r == ST_START))
    else $error("start status wrong");
  chk_flag_clear: assert property (flag_clr && !flag_set |=> !flag_r)
    else $error("flag not cleared");
  chk_wcol_set: assert property (wcol_set |=> wcol_r && (data_r == $past(data_r)))
    else $error("write collision missed");
  chk_addr_code: assert property ((sq_r == SQ_ADDR) && eng_done && !addr_rd |=> flag_r
                                  && (code_r == ST_AW_ACK || code_r == ST_AW_NACK || code_r == ST_ARB))
    else $error("address status wrong");
  chk_data_code: assert property ((sq_r == SQ_DATA) && eng_done |=> flag_r
                                  && (code_r == ($past(bif.arb_lost) ? ST_ARB : $past(bif.ack_rx) ? ST_D_ACK
                                  : ST_D_NACK)))
    else $error("data status wrong");
  chk_stop_clear: assert property (seq_stop_finish ##0 !ctrl_wr |=> !sto_r)
    else $error("stop bit stayed set");
  chk_stop_start: assert property (seq_stop_start_req |=> (sq_r == SQ_STOP) && bif.held == $past(bif.held))
    else $error("stop before start missing");
  chk_stop_then_wait: assert property (seq_stop_finish ##0 sta_r |=> sq_r == SQ_WAIT_FREE)
    else $error("start after stop missing");
  chk_lost_release: assert property (lost_release |=> unaddressed_slave ##1 !scl_oe && !sda_oe)
    else $error("bus not released");
  chk_flag_hold: assert property (flag_r && !flag_clr |-> !cmd_v)
    else $error("transfer moved while suspended");
  chk_rep_code: assert property ((sq_r == SQ_START) && eng_done && rep_r |=> code_r == ST_RSTART)
    else $error("repeated start status wrong");
  chk_irq_follow: assert property (flag_r && ie_r |=> irq)
    else $error("interrupt missing");

endmodule

// file: testbench/twm_slave_model.sv
module twm_slave_model (
  // bus lines
  input wire logic scl,
  input wire logic sda,
  // behaviour controls
  input wire logic nack,
  input wire logic arb_en,
  // observation
  output logic sda_low,
  output logic [7:0] last_byte,
  output int start_cnt,
  output int stop_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  int bit_cnt;
  logic [7:0] shift_r;
  logic ack_q;
  logic arb_q;

  initial begin
    bit_cnt = 9;
    shift_r = 8'h00;
    ack_q = 1'b0;
    arb_q = 1'b0;
    last_byte = 8'h00;
    start_cnt = 0;
    stop_cnt = 0;
  end

  // competing master holds the data line low until told to let go
  assign sda_low = ack_q | (arb_en & arb_q);

  // ------------------------------------------------------------
  // frame conditions
  // ------------------------------------------------------------
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      start_cnt++;
      bit_cnt = 0;
      arb_q = 1'b0;
      ack_q = 1'b0;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      stop_cnt++;
      bit_cnt = 9;
    end
  end

  // ------------------------------------------------------------
  // bits, msb first, ninth clock answers
  // ------------------------------------------------------------
  always @(posedge scl) begin
    if (bit_cnt < 8) begin
      shift_r = {shift_r[6:0], sda};
      bit_cnt++;
      if (bit_cnt == 8) begin
        last_byte = shift_r;
      end
    end else if (bit_cnt == 8) begin
      bit_cnt = 0;
    end
  end

  always @(negedge scl) begin
    ack_q = (bit_cnt == 8) && !nack;
    if (bit_cnt < 8 && arb_en) begin
      arb_q = 1'b1;
    end
  end
endmodule

// file: testbench/two_wire_master_transmitter_tb_top.sv
module two_wire_master_transmitter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import twm_pkg::*;
  logic clk, reset_n, reg_wr, reg_rd, nack, arb_en, slv_low;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, c, s, d, last_byte;
  logic scl_out, scl_oe, sda_out, sda_oe, irq, master_receive_mode, unaddressed_slave;
  logic [31:0] rng;
  int start_cnt, stop_cnt, n0, n1, bad_count, total_checks, cyc;
  wire scl_w = scl_oe ? scl_out : 1'b1;
  wire sda_w = (sda_oe ? sda_out : 1'b1) & ~slv_low;

  twm_master #(.HALF_CYC(4)) i_twm_master (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq),
    .master_receive_mode(master_receive_mode), .unaddressed_slave(unaddressed_slave));
  twm_slave_model i_twm_slave_model (.scl(scl_w), .sda(sda_w), .nack(nack), .arb_en(arb_en),
    .sda_low(slv_low), .last_byte(last_byte), .start_cnt(start_cnt), .stop_cnt(stop_cnt));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction

  function automatic logic [7:0] exp_code(input logic is_data, input logic nk);
    if (is_data) return nk ? ST_D_NACK : ST_D_ACK;
    return nk ? ST_AW_NACK : ST_AW_ACK;
  endfunction

  task automatic tally_and_finish();
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] e);
    total_checks++;
    if (got !== e) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    rd(CTRL_OFS, c);
    while (c[b] !== v && n < 400) begin
      rd(CTRL_OFS, c);
      n++;
    end
    if (n == 400) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, c, {7'h00, v});
      bad_count++;
    end
  endtask

  task automatic go(input logic [7:0] v);
    wr(CTRL_OFS, v);
    wait_bit(7, 1'b1);
  endtask

  task automatic stat(input logic [7:0] e);
    rd(STAT_OFS, s);
    chk(s & STAT_MASK, e);
  endtask

  task automatic stop_seq();
    n0 = stop_cnt;
    wr(CTRL_OFS, 8'h94);
    wait_bit(4, 1'b0);
    chk(c & 8'h90, 8'h00);
    stat(ST_IDLE);
    chk(8'(stop_cnt), 8'(n0 + 1));
  endtask

  // ------------------------------------------------------------
  // clock, reset, watchdog
  // ------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, cyc, 60000);
      bad_count++;
      tally_and_finish();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {reset_n, reg_wr, reg_rd, nack, arb_en, reg_addr, reg_wdata} = '0;
    rng = 32'h3387_e036;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rd(CTRL_OFS, d);
    chk(d, CTRL_RST);
    rd(2'h3, d);
    chk(d, 8'h00);
    stat(ST_IDLE);
    wr(DATA_OFS, 8'h5A);
    rd(CTRL_OFS, c);
    chk(c & 8'h08, 8'h08);
    rd(DATA_OFS, d);
    chk(d, DATA_RST);
    n1 = start_cnt;
    go(8'hA5);
    stat(ST_START);
    chk(8'(start_cnt), 8'(n1 + 1));
    chk({7'h00, irq}, 8'h01);
    rng = xs(rng);
    nack <= rng[9];
    wr(DATA_OFS, 8'h50);
    rd(CTRL_OFS, c);
    chk(c & 8'h08, 8'h00);
    go(8'h84);
    stat(exp_code(1'b0, rng[9]));
    chk(last_byte, 8'h50);
    chk({7'h00, irq}, 8'h00);
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      d = (i == 0) ? 8'hFF : rng[7:0];
      nack <= rng[8];
      wr(DATA_OFS, d);
      go(8'h84);
      stat(exp_code(1'b1, rng[8]));
      chk(last_byte, d);
    end
    repeat (40) @(posedge clk);
    #1 chk({7'h00, scl_oe}, 8'h01);
    chk({6'h00, scl_out, sda_out}, 8'h00);
    wr(CTRL_OFS, 8'h00);
    @(posedge clk);
    #1 chk({7'h00, scl_oe}, 8'h00);
    wr(CTRL_OFS, 8'h44);
    rd(CTRL_OFS, c);
    chk(c & 8'h64, 8'h44);
    n0 = stop_cnt;
    go(8'hA4);
    stat(ST_RSTART);
    chk(8'(stop_cnt), 8'(n0));
    nack <= 1'b1;
    wr(DATA_OFS, 8'hA1);
    go(8'h84);
    stat(ST_AR_NACK);
    chk({7'h00, master_receive_mode}, 8'h01);
    stop_seq();
    chk({7'h00, master_receive_mode}, 8'h00);
    nack <= 1'b0;
    go(8'hA4);
    stat(ST_START);
    wr(DATA_OFS, 8'h50);
    go(8'h84);
    stat(ST_AW_ACK);
    n0 = stop_cnt;
    n1 = start_cnt;
    go(8'hB4);
    chk(c & 8'h10, 8'h00);
    chk(8'(stop_cnt), 8'(n0 + 1));
    chk(8'(start_cnt), 8'(n1 + 1));
    stat(ST_START);
    for (int k = 0; k < 2; k++) begin
      wr(DATA_OFS, 8'h50);
      arb_en <= 1'b1;
      go(8'h84);
      stat(ST_ARB);
      if (k == 0) begin
        wr(CTRL_OFS, 8'hA4);
        repeat (60) @(posedge clk);
        rd(CTRL_OFS, c);
        chk(c & 8'h80, 8'h00);
        arb_en <= 1'b0;
        wait_bit(7, 1'b1);
        stat(ST_START);
      end else begin
        wr(CTRL_OFS, 8'h84);
        repeat (4) @(posedge clk);
        #1 chk({7'h00, unaddressed_slave}, 8'h01);
        chk({6'h00, scl_oe, sda_oe}, 8'h00);
        arb_en <= 1'b0;
      end
    end
    repeat (20) @(posedge clk);
    tally_and_finish();
  end
endmodule
